// File: src/address_breakpoint_unit.v
// Notes on behaviour
// - when enabled, a fetch at the break address raises the request.
// - only program-counter fetch addresses are compared.
// - request forces the interrupt opcode once the instruction completes.
// - vector is the user location, or the monitor page one in monitor mode.
// - a match on an instruction's last cycle starts the break at once.
// - return-from-interrupt in the handler ends the break state.
// - timer counters are halted while the break is in effect.
// - watchdog held off during break when high voltage is on reset pin.
// - flag clearing during break is governed by the flag-clear-enable bit.
// - enable bit 7 is read/write, cleared by writing zero or by reset.
// - active bit set on a match, reads one while recorded, reset clears it.
// - writing one to the active bit starts a break regardless of a match.
// - break address in high and low byte registers, consecutive addresses.
// - control register has enable in bit 7, active in bit 6.
// - reset clears both break address bytes to zero.
// - break exits stop and sets the stop/wait flag; stop keeps registers.
`timescale 1ns/10ps
`include "brk_unit_defs.vh"

module address_breakpoint_unit (
    input wire I_CLK_SYS,
    input wire I_RST,
    // classic wishbone slave
    input wire I_WB_CYC,
    input wire I_WB_STB,
    input wire I_WB_WE,
    input wire [17:0] I_WB_ADR,
    input wire [3:0] I_WB_SEL,
    input wire [31:0] I_WB_DAT,
    output reg [31:0] O_WB_DAT,
    output reg O_WB_ACK,
    // cpu core side, same clock
    input wire [15:0] I_CPU_ADDR,
    input wire I_CPU_PC_FETCH,
    input wire I_CPU_LAST_CYCLE,
    input wire I_CPU_RTI_DONE,
    input wire I_MONITOR_MODE,
    input wire I_STOP_MODE,
    input wire I_WAIT_MODE,
    // pin-derived level, asynchronous
    input wire I_RST_PIN_HIGH_VOLTAGE,
    output reg O_BREAKPOINT_REQUEST,
    output reg O_FORCE_SOFT_INTR,
    output reg [7:0] O_FORCED_OPCODE,
    output reg [15:0] O_BREAK_VECTOR,
    output reg O_BREAK_STATE,
    output reg O_TIMER_HALT,
    output reg O_WATCHDOG_HOLD,
    output reg O_FLAG_CLEAR_ALLOW,
    output reg O_STOP_EXIT,
    output reg O_IRQ
);

    reg [7:0] break_addr_high;
    reg [7:0] break_addr_low;
    reg break_enable;
    reg break_active;
    reg flag_clear_enable;
    reg stop_wait_flag;
    reg [2:0] irq_status;
    reg [2:0] irq_mask;
    reg in_break;
    reg pending;
    reg hv_meta;
    reg hv_sync;

    reg [2:0] next_irq_status;
    reg [7:0] rd_byte;

    wire access = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    wire wr = access & I_WB_WE & I_WB_SEL[0];
    wire rd = access & ~I_WB_WE;
    wire [7:0] wdat = I_WB_DAT[7:0];

    // word aligned: index sits in bits 17:2
    function hit;
        input [15:0] idx;
        begin
            hit = (I_WB_ADR[17:2] == idx) && (I_WB_ADR[1:0] == 2'b00);
        end
    endfunction

    wire match = break_enable & I_CPU_PC_FETCH &
        (I_CPU_ADDR == {break_addr_high, break_addr_low});
    wire sw_break = wr & hit(`REG_BRK_CTRL_STATUS) &
        wdat[`BIT_BREAK_ACTIVE];
    wire ctrl_wr = wr & hit(`REG_BRK_CTRL_STATUS);
    wire break_start = match | sw_break;
    wire break_end = in_break & I_CPU_RTI_DONE;

    always @* begin
        rd_byte = 8'h00;
        if (hit(`REG_BRK_ADDR_HIGH)) begin
            rd_byte = break_addr_high;
        end else if (hit(`REG_BRK_ADDR_LOW)) begin
            rd_byte = break_addr_low;
        end else if (hit(`REG_BRK_CTRL_STATUS)) begin
            rd_byte[`BIT_BREAK_ENABLE] = break_enable;
            rd_byte[`BIT_BREAK_ACTIVE] = break_active;
        end else if (hit(`REG_BRK_FLAG_CTRL)) begin
            rd_byte[`BIT_FLAG_CLEAR_EN] = flag_clear_enable;
            rd_byte[`BIT_STOP_WAIT_FLAG] = stop_wait_flag;
        end else if (hit(`REG_IRQ_STATUS)) begin
            rd_byte = {5'h00, irq_status};
        end else if (hit(`REG_IRQ_MASK)) begin
            rd_byte = {5'h00, irq_mask};
        end
    end

    // events set over a read-clear in the same cycle
    always @* begin
        next_irq_status = irq_status;
        if (rd & hit(`REG_IRQ_STATUS)) begin
            next_irq_status = 3'h0;
        end
        if (match) begin
            next_irq_status[`BIT_EV_MATCH] = 1'b1;
        end
        if (sw_break) begin
            next_irq_status[`BIT_EV_SW_BREAK] = 1'b1;
        end
        if (break_end) begin
            next_irq_status[`BIT_EV_BREAK_END] = 1'b1;
        end
    end

    // bus slave: one wait-free ack, unmapped reads zero, writes ignored
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h00000000;
        end else begin
            O_WB_ACK <= access;
            if (rd) begin
                O_WB_DAT <= {24'h000000, rd_byte};
            end
        end
    end

    // high voltage level comes from a pin comparator
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            hv_meta <= 1'b0;
            hv_sync <= 1'b0;
        end else begin
            hv_meta <= I_RST_PIN_HIGH_VOLTAGE;
            hv_sync <= hv_meta;
        end
    end

    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            break_addr_high <= `RST_BRK_ADDR;
            break_addr_low <= `RST_BRK_ADDR;
            break_enable <= 1'b0;
            break_active <= 1'b0;
            flag_clear_enable <= 1'b0;
            stop_wait_flag <= 1'b0;
            irq_status <= 3'h0;
            irq_mask <= 3'h0;
        end else begin
            irq_status <= next_irq_status;
            if (wr & hit(`REG_BRK_ADDR_HIGH)) begin
                break_addr_high <= wdat;
            end
            if (wr & hit(`REG_BRK_ADDR_LOW)) begin
                break_addr_low <= wdat;
            end
            if (ctrl_wr) begin
                break_enable <= wdat[`BIT_BREAK_ENABLE];
            end
            if (match | sw_break) begin
                break_active <= 1'b1;
            end else if (ctrl_wr) begin
                break_active <= 1'b0;
            end
            if (wr & hit(`REG_BRK_FLAG_CTRL)) begin
                flag_clear_enable <= wdat[`BIT_FLAG_CLEAR_EN];
            end
            if (break_start & (I_STOP_MODE | I_WAIT_MODE)) begin
                stop_wait_flag <= 1'b1;
            end else if (wr & hit(`REG_BRK_FLAG_CTRL) &
                         ~wdat[`BIT_STOP_WAIT_FLAG]) begin
                stop_wait_flag <= 1'b0;
            end
            if (wr & hit(`REG_IRQ_MASK)) begin
                irq_mask <= wdat[2:0];
            end
        end
    end

    // break sequencing toward the core
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            in_break <= 1'b0;
            pending <= 1'b0;
            O_BREAKPOINT_REQUEST <= 1'b0;
            O_FORCE_SOFT_INTR <= 1'b0;
            O_FORCED_OPCODE <= `RST_BYTE;
            O_BREAK_VECTOR <= `VEC_USER_BREAK;
            O_BREAK_STATE <= 1'b0;
            O_TIMER_HALT <= 1'b0;
            O_WATCHDOG_HOLD <= 1'b0;
            O_FLAG_CLEAR_ALLOW <= 1'b1;
            O_STOP_EXIT <= 1'b0;
            O_IRQ <= 1'b0;
        end else begin
            O_FORCE_SOFT_INTR <= 1'b0;
            O_STOP_EXIT <= 1'b0;
            O_BREAKPOINT_REQUEST <= (break_start | pending) & ~in_break;
            if (break_start & ~in_break) begin
                pending <= 1'b1;
            end
            if ((pending | break_start) & ~in_break & I_CPU_LAST_CYCLE) begin
                pending <= 1'b0;
                in_break <= 1'b1;
                O_FORCE_SOFT_INTR <= 1'b1;
                O_FORCED_OPCODE <= `OPC_SOFT_INTR;
                O_BREAK_VECTOR <= I_MONITOR_MODE ? `VEC_MON_BREAK :
                    `VEC_USER_BREAK;
            end else if (break_end) begin
                in_break <= 1'b0;
            end
            if (break_start & I_STOP_MODE) begin
                O_STOP_EXIT <= 1'b1;
            end
            O_BREAK_STATE <= in_break;
            O_TIMER_HALT <= in_break;
            O_WATCHDOG_HOLD <= in_break & hv_sync;
            O_FLAG_CLEAR_ALLOW <= ~in_break | flag_clear_enable;
            O_IRQ <= |(next_irq_status & irq_mask);
        end
    end

endmodule

// File: src/brk_unit_defs.vh
`ifndef BRK_UNIT_DEFS_VH
`define BRK_UNIT_DEFS_VH

// register indices (printed offsets); byte address = index * 4
`define REG_BRK_ADDR_HIGH 16'hfe0c
`define REG_BRK_ADDR_LOW 16'hfe0d
`define REG_BRK_CTRL_STATUS 16'hfe0e
`define REG_BRK_FLAG_CTRL 16'hfe0f
`define REG_IRQ_STATUS 16'hfe10
`define REG_IRQ_MASK 16'hfe11

// break control/status fields
`define BIT_BREAK_ENABLE 7
`define BIT_BREAK_ACTIVE 6
`define MASK_BRK_CTRL 8'hc0
// break flag control fields
`define BIT_FLAG_CLEAR_EN 7
`define BIT_STOP_WAIT_FLAG 0
// interrupt status fields
`define BIT_EV_MATCH 0
`define BIT_EV_SW_BREAK 1
`define BIT_EV_BREAK_END 2

// reset values
`define RST_BRK_ADDR 8'h00
`define RST_BRK_CTRL 8'h00
`define RST_BYTE 8'h00

// break vectors (high byte address; low byte follows)
`define VEC_USER_BREAK 16'hfffc
`define VEC_MON_BREAK 16'hfefc

// opcode placed into the instruction register for a break
`define OPC_SOFT_INTR 8'h83

`endif

// File: tb/cpu_core_model.sv
`timescale 1ns/10ps
module cpu_core_model (
    input wire clk,
    input wire rst,
    input wire i_load,
    input wire [15:0] i_pc,
    input wire i_force,
    input wire i_fetch_last,
    output wire [15:0] o_addr,
    output wire o_fetch,
    output wire o_last,
    output reg o_rti
);
reg [15:0] pc;
reg [4:0] hcnt;
reg ph;
// odd cycles are data accesses at the inverted address
assign o_fetch = ~ph;
assign o_addr = ph ? ~pc : pc;
assign o_last = ph | i_fetch_last;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        pc <= 16'h0000;
        ph <= 1'b0;
        hcnt <= 5'h00;
        o_rti <= 1'b0;
    end else begin
        ph <= ~ph;
        pc <= i_load ? i_pc : pc + {15'h0000, ph};
        hcnt <= i_force ? 5'h18 : hcnt - {4'h0, hcnt != 5'h00};
        o_rti <= hcnt == 5'h01;
    end
end
endmodule

// File: tb/address_breakpoint_unit_props.sv
`timescale 1ns/10ps
`include "brk_unit_defs.vh"
module abu_props (
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire I_WB_CYC,
    input wire I_WB_STB,
    input wire I_MONITOR_MODE,
    input wire I_CPU_RTI_DONE,
    input wire O_WB_ACK,
    input wire O_BREAKPOINT_REQUEST,
    input wire O_FORCE_SOFT_INTR,
    input wire [7:0] O_FORCED_OPCODE,
    input wire [15:0] O_BREAK_VECTOR,
    input wire O_BREAK_STATE,
    input wire O_TIMER_HALT,
    input wire O_WATCHDOG_HOLD,
    input wire O_FLAG_CLEAR_ALLOW
);
default clocking cb @(posedge I_CLK_SYS);
endclocking
default disable iff (I_RST);
AST_ACK_LAT: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK
    |=> O_WB_ACK) else $error("late ack");
AST_FORCE_SEQ: assert property (O_FORCE_SOFT_INTR |->
    O_BREAKPOINT_REQUEST ##1 O_BREAK_STATE && !O_BREAKPOINT_REQUEST)
    else $error("bad force");
AST_OPCODE: assert property (O_FORCE_SOFT_INTR |=>
    O_FORCED_OPCODE == `OPC_SOFT_INTR) else $error("bad opcode");
AST_VECTOR: assert property ($rose(O_BREAK_STATE) |-> O_BREAK_VECTOR ==
    (I_MONITOR_MODE ? `VEC_MON_BREAK : `VEC_USER_BREAK)) else $error("vector");
AST_TIMER: assert property (O_TIMER_HALT == O_BREAK_STATE)
    else $error("timer halt");
AST_WDOG: assert property (O_WATCHDOG_HOLD |-> O_BREAK_STATE
    || $past(O_BREAK_STATE)) else $error("watchdog hold");
AST_FLAG: assert property (!O_FLAG_CLEAR_ALLOW |-> O_BREAK_STATE
    || $past(O_BREAK_STATE)) else $error("flag clear");
AST_RTI_END: assert property (O_BREAK_STATE && I_CPU_RTI_DONE |->
    ##[1:2] !O_BREAK_STATE) else $error("break not ended");
endmodule
bind address_breakpoint_unit abu_props u_props (.I_CLK_SYS(I_CLK_SYS),
    .I_RST(I_RST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_MONITOR_MODE(I_MONITOR_MODE), .I_CPU_RTI_DONE(I_CPU_RTI_DONE),
    .O_WB_ACK(O_WB_ACK), .O_BREAKPOINT_REQUEST(O_BREAKPOINT_REQUEST),
    .O_FORCE_SOFT_INTR(O_FORCE_SOFT_INTR), .O_FORCED_OPCODE(O_FORCED_OPCODE),
    .O_BREAK_VECTOR(O_BREAK_VECTOR), .O_BREAK_STATE(O_BREAK_STATE),
    .O_TIMER_HALT(O_TIMER_HALT), .O_WATCHDOG_HOLD(O_WATCHDOG_HOLD),
    .O_FLAG_CLEAR_ALLOW(O_FLAG_CLEAR_ALLOW));

// File: tb/address_breakpoint_unit_test.sv
`timescale 1ns/10ps
`include "brk_unit_defs.vh"
module address_breakpoint_unit_test;
reg clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, mon = 0, hv = 0;
reg stp = 0, load = 0, flast = 0;
reg [17:0] adr = 0;
reg [31:0] dat = 0, seed = 32'hcea7, q;
reg [15:0] pc = 0, ba;
wire [31:0] rd;
wire [15:0] vec, ca;
wire [7:0] opc;
wire ack, req, frc, bst, th, wdh, fca, irq, fe, la, return_from_interrupt_instr, sx;
integer num_errors = 0, n_compared = 0, i, k, n_stop_exit = 0;
always #2.5 clk = ~clk;
always @(posedge clk) begin
    if (sx === 1'b1)
        n_stop_exit <= n_stop_exit + 1;
end
address_breakpoint_unit dut (.I_CLK_SYS(clk), .I_RST(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf),
    .I_WB_DAT(dat), .O_WB_DAT(rd), .O_WB_ACK(ack), .I_CPU_ADDR(ca),
    .I_CPU_PC_FETCH(fe), .I_CPU_LAST_CYCLE(la), .I_CPU_RTI_DONE(return_from_interrupt_instr),
    .I_MONITOR_MODE(mon), .I_STOP_MODE(stp), .I_WAIT_MODE(1'b0),
    .I_RST_PIN_HIGH_VOLTAGE(hv), .O_BREAKPOINT_REQUEST(req),
    .O_FORCE_SOFT_INTR(frc), .O_FORCED_OPCODE(opc), .O_BREAK_VECTOR(vec),
    .O_BREAK_STATE(bst), .O_TIMER_HALT(th), .O_WATCHDOG_HOLD(wdh),
    .O_FLAG_CLEAR_ALLOW(fca), .O_STOP_EXIT(sx), .O_IRQ(irq));
cpu_core_model cpu (.clk(clk), .rst(rst), .i_load(load), .i_pc(pc),
    .i_force(frc), .i_fetch_last(flast), .o_addr(ca), .o_fetch(fe),
    .o_last(la), .o_rti(return_from_interrupt_instr));
function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task chk(input [31:0] s, input [31:0] e);
    begin
        n_compared = n_compared + 1;
        if (s !== e) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    end
endtask
task results;
    begin
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
endtask
task wt(input m, input v);
    for (k = 0; (m ? bst : ack) !== v; k = k + 1) begin
        if (k == 60) begin
            chk(k, 0);
            results;
        end
        @(posedge clk);
    end
endtask
task wb(input w, input [15:0] a, input [7:0] d);
    begin
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {a, 2'b00};
        dat <= {24'h0, d};
        @(posedge clk);
        wt(0, 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    end
endtask
initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
        wb(0, `REG_BRK_ADDR_HIGH + i, 8'h00);
        chk(q, 0);
    end
    for (i = 0; i < 4; i = i + 1) begin
        seed = lfsr(seed);
        ba = {4'h1, seed[11:0]};
        mon <= seed[12];
        flast <= seed[13];
        hv <= seed[14];
        // data accesses hit the break address, fetches do not
        pc <= ~ba;
        load <= 1'b1;
        wb(1, `REG_BRK_ADDR_HIGH, ba[15:8]);
        wb(1, `REG_BRK_ADDR_LOW, ba[7:0]);
        wb(0, `REG_BRK_ADDR_HIGH, 8'h00);
        chk(q, {24'h0, ba[15:8]});
        wb(0, `REG_BRK_ADDR_LOW, 8'h00);
        chk(q, {24'h0, ba[7:0]});
        wb(1, `REG_IRQ_MASK, 8'h07);
        wb(1, `REG_BRK_FLAG_CTRL, {seed[15], 7'h00});
        wb(1, `REG_BRK_CTRL_STATUS, 8'hbf);
        wb(0, `REG_BRK_CTRL_STATUS, 8'h00);
        chk(q, 32'h80);
        chk(req, 0);
        // the model samples the new start address only while load stands
        pc <= ba - 16'h0002;
        @(posedge clk);
        load <= 1'b0;
        wt(1, 1'b1);
        chk(th, 1);
        chk(vec, mon ? `VEC_MON_BREAK : `VEC_USER_BREAK);
        chk(wdh, hv);
        chk(fca, seed[15]);
        chk(opc, `OPC_SOFT_INTR);
        chk(irq, 1);
        wb(0, `REG_BRK_CTRL_STATUS, 8'h00);
        chk(q, 32'hc0);
        wb(0, `REG_IRQ_STATUS, 8'h00);
        chk(q, 32'h01);
        wb(1, `REG_BRK_CTRL_STATUS, 8'h00);
        wt(1, 1'b0);
        wb(0, `REG_IRQ_STATUS, 8'h00);
        chk(q, 32'h04);
        wb(0, `REG_BRK_CTRL_STATUS, 8'h00);
        chk(q, 32'h00);
        chk(irq, 0);
    end
    stp <= 1'b1;
    wb(1, `REG_BRK_CTRL_STATUS, 8'h40);
    wt(1, 1'b1);
    wb(0, `REG_IRQ_STATUS, 8'h00);
    chk(q, 32'h02);
    wb(0, `REG_BRK_FLAG_CTRL, 8'h00);
    chk(q, {24'h0, seed[15], 6'h00, 1'b1});
    chk(n_stop_exit, 1);
    results;
end
endmodule
